// ### hw/isu_intr_status.sv
`timescale 1ns/1ps
`default_nettype none
module isu_intr_status
    import isu_pkg::*;
#(
    parameter int DEPTH = TX_DEPTH,
    parameter int WIDTH = TX_WIDTH,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register read port
    input wire logic regRead,
    input wire logic [31:0] regAddr,
    output logic [STAT_W-1:0] regRdata_r,
    // processor side controls and clear-on-read strobes
    input wire logic controllerEnableBit,
    input wire logic [STAT_W-1:0] interruptMask,
    input wire logic [LVL_W-1:0] txThreshold,
    input wire logic genCallClrRead,
    input wire logic activityClrRead,
    input wire logic combinedClrRead,
    input wire logic abortClrRead,
    input wire logic readReqClrRead,
    input wire logic dataCmdWrite,
    input wire logic [WIDTH-1:0] dataCmdData,
    // bus engine events
    input wire logic genCallAcked,
    input wire logic startSeen,
    input wire logic stopSeen,
    input wire logic masterActive,
    input wire logic slaveActive,
    input wire logic slaveTxNack,
    input wire logic txAbortEvent,
    input wire logic [ABORT_W-1:0] abortCause,
    input wire logic slaveReadReq,
    input wire logic rxByteValid,
    input wire logic [RX_W-1:0] rxByte,
    input wire logic txPop,
    // engine facing outputs
    output logic [WIDTH-1:0] txHead_r,
    output logic txAvail_r,
    output logic sclHoldLow_r,
    output logic rxPush_r,
    output logic [RX_W-1:0] rxPushData_r,
    // status
    output logic [STAT_W-1:0] interruptStatus_r,
    output logic [STAT_W-1:0] rawStatus_r,
    output logic [ABORT_W-1:0] abortReason_r,
    output logic internalEnableSignal_r
);
    logic genCallFlag;
    logic startFlag;
    logic stopFlag;
    logic activityFlag;
    logic slvDoneFlag;
    logic abortFlag;
    logic rdReqFlag;
    logic txEmptyFlag_r;
    logic overFlag;
    logic busy;
    logic disabled;
    logic txFlush;
    logic txFull;
    logic rdPending_r;
    logic genCallPhase_r;
    logic [WIDTH-1:0] fifoHead;
    logic fifoNotEmpty;
    logic [LVL_W-1:0] fifoLevel;
    logic [STAT_W-1:0] raw;

    assign busy = masterActive || slaveActive;
    assign disabled = !controllerEnableBit;
    // abort or disable keeps the queue empty
    assign txFlush = abortFlag || disabled;
    assign txFull = (fifoLevel == LVL_W'(DEPTH));

    // internal enable falls only once both state machines are idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internalEnableSignal_r <= 1'b0;
        end else if (controllerEnableBit) begin
            internalEnableSignal_r <= 1'b1;
        end else if (!busy) begin
            internalEnableSignal_r <= 1'b0;
        end
    end

    isu_sticky_flag u_gen_call (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(genCallAcked && controllerEnableBit),
        .clrEv(genCallClrRead || combinedClrRead || disabled),
        .flag_r(genCallFlag)
    );

    isu_sticky_flag u_start (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(startSeen),
        .clrEv(combinedClrRead || disabled),
        .flag_r(startFlag)
    );

    isu_sticky_flag u_stop (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(stopSeen),
        .clrEv(combinedClrRead || disabled),
        .flag_r(stopFlag)
    );

    // idle does not clear it; only the listed actions do
    isu_sticky_flag u_activity (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(busy),
        .clrEv(disabled || activityClrRead || combinedClrRead),
        .flag_r(activityFlag)
    );

    isu_sticky_flag u_slv_done (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(slaveTxNack && slaveActive),
        .clrEv(combinedClrRead || disabled),
        .flag_r(slvDoneFlag)
    );

    isu_sticky_flag u_abort (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(txAbortEvent),
        .clrEv(abortClrRead || combinedClrRead),
        .flag_r(abortFlag)
    );

    isu_sticky_flag u_rd_req (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(slaveReadReq),
        .clrEv(readReqClrRead || combinedClrRead),
        .flag_r(rdReqFlag)
    );

    // cleared by the combined clear read or when internal enable is low, not by the enable bit
    isu_sticky_flag u_over (
        .clk(clk),
        .rst_n(rst_n),
        .setEv(dataCmdWrite && txFull && !txFlush),
        .clrEv(combinedClrRead || !internalEnableSignal_r),
        .flag_r(overFlag)
    );

    isu_tx_fifo #(
        .DEPTH(DEPTH),
        .WIDTH(WIDTH),
        .LVL_W(LVL_W)
    ) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(txFlush),
        .push(dataCmdWrite),
        .pushData(dataCmdData),
        .pop(txPop),
        .headData_r(fifoHead),
        .notEmpty_r(fifoNotEmpty),
        .level_r(fifoLevel)
    );

    // level flag; disabled it reports whether the engines still run
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txEmptyFlag_r <= 1'b0;
        end else if (disabled) begin
            txEmptyFlag_r <= busy;
        end else begin
            txEmptyFlag_r <= (fifoLevel <= txThreshold);
        end
    end

    // abort cause kept with the flag and dropped when it clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            abortReason_r <= '0;
        end else if (txAbortEvent) begin
            abortReason_r <= abortCause;
        end else if (abortClrRead || combinedClrRead) begin
            abortReason_r <= '0;
        end
    end

    // clock stays low from the request until the processor queues a byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdPending_r <= 1'b0;
            sclHoldLow_r <= 1'b0;
        end else begin
            if (slaveReadReq) begin
                rdPending_r <= 1'b1;
            end else if (fifoNotEmpty || disabled) begin
                rdPending_r <= 1'b0;
            end
            sclHoldLow_r <= (slaveReadReq || rdPending_r)
                && !fifoNotEmpty && !disabled;
        end
    end

    // bytes after an acknowledged general call up to the stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            genCallPhase_r <= 1'b0;
            rxPush_r <= 1'b0;
            rxPushData_r <= '0;
        end else begin
            if (genCallAcked && controllerEnableBit) begin
                genCallPhase_r <= 1'b1;
            end else if (stopSeen || disabled) begin
                genCallPhase_r <= 1'b0;
            end
            rxPush_r <= genCallPhase_r && rxByteValid;
            rxPushData_r <= rxByte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txHead_r <= '0;
            txAvail_r <= 1'b0;
        end else begin
            txHead_r <= fifoHead;
            txAvail_r <= fifoNotEmpty && !txFlush && !txPop;
        end
    end

    // reserved and receive-side bits stay zero
    always_comb begin
        raw = '0;
        raw[BIT_GEN_CALL] = genCallFlag;
        raw[BIT_START] = startFlag;
        raw[BIT_STOP] = stopFlag;
        raw[BIT_ACTIVITY] = activityFlag;
        raw[BIT_SLV_DONE] = slvDoneFlag;
        raw[BIT_TX_ABORT] = abortFlag;
        raw[BIT_RD_REQ] = rdReqFlag;
        raw[BIT_TX_EMPTY] = txEmptyFlag_r;
        raw[BIT_TX_OVER] = overFlag;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rawStatus_r <= RESET_INTR_STATUS;
            interruptStatus_r <= RESET_INTR_STATUS;
            regRdata_r <= RESET_INTR_STATUS;
        end else begin
            rawStatus_r <= raw;
            interruptStatus_r <= raw & interruptMask;
            if (regRead && (regAddr == ADDR_INTR_STATUS)) begin
                regRdata_r <= raw & interruptMask;
            end else begin
                regRdata_r <= '0;
            end
        end
    end

    a_gen_call_only: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(genCallFlag) |-> $past(genCallAcked))
        else $error("general call flag rose without acknowledged call");

    a_gen_call_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (genCallClrRead && !genCallAcked) |=> !genCallFlag)
        else $error("general call flag not cleared by its clear read");

    a_start_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        startSeen |=> ##1 rawStatus_r[BIT_START])
        else $error("start condition not reported");

    a_activity_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        (activityFlag && controllerEnableBit && !activityClrRead
         && !combinedClrRead) |=> activityFlag)
        else $error("activity flag dropped without a clearing action");

    a_abort_flush: assert property (
        @(posedge clk) disable iff (!rst_n)
        abortFlag |=> (fifoLevel == '0) && !txAvail_r)
        else $error("transmit queue not empty during abort");

    a_scl_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (slaveReadReq && !fifoNotEmpty && controllerEnableBit)
        |=> sclHoldLow_r)
        else $error("clock not held low on read request");

    a_rd_req_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (readReqClrRead && !slaveReadReq) |=> ##1 !rawStatus_r[BIT_RD_REQ])
        else $error("read request flag not cleared after clear read");

    a_over_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dataCmdWrite && fifoLevel == LVL_W'(DEPTH) && !txFlush)
        |=> overFlag && (fifoLevel == LVL_W'(DEPTH) - LVL_W'($past(txPop))))
        else $error("overflow not flagged on write to full queue");

    a_over_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!internalEnableSignal_r && !dataCmdWrite) |=> !overFlag)
        else $error("overflow flag survived internal disable");

    a_mask_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 interruptStatus_r == ($past(raw) & $past(interruptMask)))
        else $error("masked status does not follow mask");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        rawStatus_r[STAT_W-1:BIT_GEN_CALL+1] == '0)
        else $error("reserved status bits not zero");
endmodule // isu_intr_status
`default_nettype wire

// ### hw/isu_pkg.sv
package isu_pkg;
    // status bit positions
    localparam int BIT_GEN_CALL = 11;
    localparam int BIT_START = 10;
    localparam int BIT_STOP = 9;
    localparam int BIT_ACTIVITY = 8;
    localparam int BIT_SLV_DONE = 7;
    localparam int BIT_TX_ABORT = 6;
    localparam int BIT_RD_REQ = 5;
    localparam int BIT_TX_EMPTY = 4;
    localparam int BIT_TX_OVER = 3;
    localparam int STAT_W = 16;
    // register map
    localparam logic [31:0] ADDR_INTR_STATUS = 32'h5000132C;
    localparam logic [STAT_W-1:0] RESET_INTR_STATUS = 16'h0000;
    // documented depth of the transmit queue
    localparam int TX_DEPTH = 32;
    localparam int TX_WIDTH = 9;
    localparam int ABORT_W = 16;
    localparam int RX_W = 8;
endpackage : isu_pkg

// ### hw/isu_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module isu_sticky_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic setEv,
    input wire logic clrEv,
    // state
    output logic flag_r
);
    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (setEv) begin
            flag_r <= 1'b1;
        end else if (clrEv) begin
            flag_r <= 1'b0;
        end
    end
endmodule // isu_sticky_flag
`default_nettype wire

// ### hw/isu_tx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module isu_tx_fifo #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 9,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] pushData,
    input wire logic pop,
    // state
    output logic [WIDTH-1:0] headData_r,
    output logic notEmpty_r,
    output logic [LVL_W-1:0] level_r
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [PTR_W-1:0] rdPtr_nxt;
    logic [LVL_W-1:0] level_nxt;
    logic doPush;
    logic doPop;

    assign doPush = push && (level_r != LVL_W'(DEPTH)) && !flush;
    assign doPop = pop && notEmpty_r && !flush;
    assign rdPtr_nxt = doPop ? PTR_W'(rdPtr_r + 1'b1) : rdPtr_r;
    assign level_nxt = flush ? '0 : LVL_W'(level_r + doPush - doPop);

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_r] <= pushData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            level_r <= '0;
            notEmpty_r <= 1'b0;
            headData_r <= '0;
        end else begin
            wrPtr_r <= flush ? '0 : (doPush ? PTR_W'(wrPtr_r + 1'b1)
                                            : wrPtr_r);
            rdPtr_r <= flush ? '0 : rdPtr_nxt;
            level_r <= level_nxt;
            notEmpty_r <= (level_nxt != '0);
            // bypass when the head is written this very cycle
            if (doPush && (wrPtr_r == rdPtr_nxt)) begin
                headData_r <= pushData;
            end else begin
                headData_r <= mem[rdPtr_nxt];
            end
        end
    end
endmodule // isu_tx_fifo
`default_nettype wire

// ### test/isu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module isu_bus_model (
    // clock
    input wire logic clk,
    // bus events toward the status block
    output wire logic startSeen,
    output wire logic genCallAcked,
    output wire logic rxByteValid,
    output wire logic stopSeen,
    output wire logic slaveTxNack,
    output wire logic txAbortEvent,
    output wire logic slaveReadReq,
    output wire logic txPop,
    output wire logic [7:0] rxByte,
    output wire logic [15:0] abortCause,
    // state machine activity
    output logic masterActive,
    output logic slaveActive
);
    logic [7:0] evVec;
    logic [15:0] dataR;
    assign {txPop, slaveReadReq, txAbortEvent, slaveTxNack, stopSeen,
        rxByteValid, genCallAcked, startSeen} = evVec;
    assign rxByte = dataR[7:0];
    assign abortCause = dataR;
    initial begin
        evVec = 8'h00;
        dataR = 16'hFFFF;
        masterActive = 1'b0;
        slaveActive = 1'b0;
    end
    // one-cycle event; data is inverted once released so stale values fail
    task automatic ev(input int sel, input logic [15:0] d);
        @(posedge clk);
        evVec <= 8'h01 << sel;
        dataR <= d;
        @(posedge clk);
        evVec <= 8'h00;
        dataR <= ~d;
    endtask
    task automatic busy(input logic m, input logic s);
        @(posedge clk);
        masterActive <= m;
        slaveActive <= s;
    endtask
endmodule // isu_bus_model
`default_nettype wire

// ### test/isu_intr_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module isu_intr_status_bench
    import isu_pkg::*;
;
    localparam int EV_START = 0;
    localparam int EV_GCALL = 1;
    localparam int EV_BYTE = 2;
    localparam int EV_STOP = 3;
    localparam int EV_NACK = 4;
    localparam int EV_ABORT = 5;
    localparam int EV_RDREQ = 6;
    localparam int EV_POP = 7;
    localparam int C_GCALL = 0;
    localparam int C_ACT = 1;
    localparam int C_ALL = 2;
    localparam int C_ABORT = 3;
    localparam int C_RDREQ = 4;
    localparam int C_WRITE = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regAddr = 32'h00000000;
    logic enable = 1'b0;
    logic [STAT_W-1:0] mask = 16'hFFFF;
    logic [$clog2(TX_DEPTH+1)-1:0] thr = 6'h04;
    logic [5:0] clrVec = 6'h00;
    logic [TX_WIDTH-1:0] cmdData = 9'h000;
    logic startS, gcAck, rxValid, stopS, nack, abortEv, rdReq, pop;
    logic mActive, sActive;
    logic [7:0] rxByte;
    logic [15:0] cause;
    logic [TX_WIDTH-1:0] txHead;
    logic txAvail, sclHold, rxPush, intEn;
    logic [7:0] rxData;
    logic [15:0] rdData, intrStat, rawStat, abortReason;
    int err_total = 0;
    int num_checks = 0;

    always #50 clk = ~clk;

    isu_bus_model u_isu_bus_model (.clk(clk), .startSeen(startS),
        .genCallAcked(gcAck), .rxByteValid(rxValid), .stopSeen(stopS),
        .slaveTxNack(nack), .txAbortEvent(abortEv), .slaveReadReq(rdReq),
        .txPop(pop), .rxByte(rxByte), .abortCause(cause),
        .masterActive(mActive), .slaveActive(sActive));

    isu_intr_status u_isu_intr_status (.clk(clk), .rst_n(rst_n),
        .regRead(regRead), .regAddr(regAddr), .regRdata_r(rdData),
        .controllerEnableBit(enable), .interruptMask(mask),
        .txThreshold(thr), .genCallClrRead(clrVec[C_GCALL]),
        .activityClrRead(clrVec[C_ACT]), .combinedClrRead(clrVec[C_ALL]),
        .abortClrRead(clrVec[C_ABORT]), .readReqClrRead(clrVec[C_RDREQ]),
        .dataCmdWrite(clrVec[C_WRITE]), .dataCmdData(cmdData),
        .genCallAcked(gcAck), .startSeen(startS), .stopSeen(stopS),
        .masterActive(mActive), .slaveActive(sActive),
        .slaveTxNack(nack), .txAbortEvent(abortEv), .abortCause(cause),
        .slaveReadReq(rdReq), .rxByteValid(rxValid), .rxByte(rxByte),
        .txPop(pop), .txHead_r(txHead), .txAvail_r(txAvail),
        .sclHoldLow_r(sclHold), .rxPush_r(rxPush), .rxPushData_r(rxData),
        .interruptStatus_r(intrStat), .rawStatus_r(rawStat),
        .abortReason_r(abortReason), .internalEnableSignal_r(intEn));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    // waits past the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic strobe(input int b, input logic [8:0] d);
        @(posedge clk);
        clrVec <= 6'h01 << b;
        cmdData <= d;
        @(posedge clk);
        clrVec <= 6'h00;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(rdData, e);
    endtask

    task automatic test_reset();
        chk(rawStat, 16'h0000);
        rd_chk(ADDR_INTR_STATUS, RESET_INTR_STATUS);
    endtask
    task automatic test_gen_call();
        @(posedge clk);
        enable <= 1'b1;
        tick(3);
        chk(rawStat, 16'h0010);
        u_isu_bus_model.busy(1'b0, 1'b1);
        u_isu_bus_model.ev(EV_START, 16'h0000);
        u_isu_bus_model.ev(EV_GCALL, 16'h0000);
        u_isu_bus_model.ev(EV_BYTE, 16'h00A5);
        tick(0);
        for (int i = 0; i < 4 && rxPush !== 1'b1; i++) tick(1);
        chk({7'h00, rxPush, rxData}, 16'h01A5);
        u_isu_bus_model.ev(EV_STOP, 16'h0000);
        u_isu_bus_model.busy(1'b0, 1'b0);
        tick(3);
        chk(rawStat, 16'h0F10);
        rd_chk(32'h50001330, 16'h0000);
        strobe(C_GCALL, 9'h000);
        tick(3);
        chk(rawStat, 16'h0710);
        strobe(C_ACT, 9'h000);
        tick(3);
        chk(rawStat, 16'h0610);
        @(posedge clk);
        mask <= 16'hFBFF;
        tick(3);
        rd_chk(ADDR_INTR_STATUS, 16'h0210);
        @(posedge clk);
        mask <= 16'hFFFF;
    endtask
    task automatic test_read_req();
        u_isu_bus_model.ev(EV_RDREQ, 16'h0000);
        tick(3);
        chk({sclHold, 9'h000, rawStat[5:0]}, 16'h8030);
        strobe(C_WRITE, 9'h03C);
        tick(4);
        chk({6'h00, sclHold, txAvail, txHead[7:0]}, 16'h013C);
        strobe(C_RDREQ, 9'h000);
        tick(3);
        chk(rawStat & 16'h0020, 16'h0000);
        u_isu_bus_model.ev(EV_POP, 16'h0000);
        tick(3);
    endtask
    task automatic test_abort();
        strobe(C_WRITE, 9'h011);
        strobe(C_WRITE, 9'h122);
        u_isu_bus_model.ev(EV_ABORT, 16'h0021);
        tick(3);
        chk(rawStat & 16'h0040, 16'h0040);
        chk(abortReason, 16'h0021);
        strobe(C_WRITE, 9'h033);
        tick(3);
        chk({15'h0000, txAvail}, 16'h0000);
        strobe(C_ABORT, 9'h000);
        tick(3);
        chk(rawStat & 16'h0040, 16'h0000);
        strobe(C_WRITE, 9'h144);
        tick(3);
        chk({6'h00, txAvail, txHead}, 16'h0344);
        u_isu_bus_model.ev(EV_POP, 16'h0000);
        tick(3);
    endtask
    task automatic test_slave_done();
        // a nack outside slave operation must not count as done
        u_isu_bus_model.ev(EV_NACK, 16'h0000);
        tick(3);
        chk(rawStat & 16'h0080, 16'h0000);
        u_isu_bus_model.busy(1'b0, 1'b1);
        u_isu_bus_model.ev(EV_NACK, 16'h0000);
        u_isu_bus_model.busy(1'b0, 1'b0);
        tick(3);
        chk(rawStat & 16'h0080, 16'h0080);
        @(posedge clk);
        mask <= 16'hFF7F;
        tick(3);
        chk(intrStat & 16'h0080, 16'h0000);
        @(posedge clk);
        mask <= 16'hFFFF;
        strobe(C_ALL, 9'h000);
        tick(3);
        chk(rawStat, 16'h0010);
    endtask
    task automatic test_overflow();
        for (int i = 0; i < TX_DEPTH; i++) strobe(C_WRITE, 9'(i));
        tick(3);
        chk(rawStat & 16'h0018, 16'h0000);
        strobe(C_WRITE, 9'h1FF);
        tick(3);
        chk(rawStat & 16'h0018, 16'h0008);
        u_isu_bus_model.busy(1'b1, 1'b0);
        @(posedge clk);
        enable <= 1'b0;
        tick(3);
        chk({intEn, 10'h000, rawStat[4:0]}, 16'h8018);
        u_isu_bus_model.busy(1'b0, 1'b0);
        tick(3);
        chk(rawStat, 16'h0000);
        chk({14'h0000, intEn, txAvail}, 16'h0000);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        test_reset();
        test_gen_call();
        test_read_req();
        test_abort();
        test_slave_done();
        test_overflow();
        finish_test();
    end
    // run needs about 210 cycles; allow well over ten times that
    initial begin
        #500000;
        err_total++;
        finish_test();
    end
endmodule // isu_intr_status_bench
`default_nettype wire
